//--- hw/accel_regs_consts.svh
// Purpose: Named offsets, fields, reset values and codes of the
//          sensor status and configuration register slice.
// Assumes: Included by bare name.
// Notes:   Register byte address is four times the index.
`ifndef ACCEL_REGS_CONSTS_SVH
`define ACCEL_REGS_CONSTS_SVH

// Register indexes
`define IDX_FILL_LO   10'h024
`define IDX_FILL_HI   10'h025
`define IDX_RD_PORT   10'h026
`define IDX_MOTION    10'h027
`define IDX_STATE     10'h02a
`define IDX_IRQ_STAT  10'h030
`define IDX_IRQ_MASK  10'h031
`define IDX_CONF      10'h040

// Reset values and the byte read from an empty read port
`define CONF_RST      8'ha8
`define IRQ_MASK_RST  3'h0
`define EMPTY_BYTE    8'h00

// Field limits and positions
`define ODR_MIN       4'h1
`define ODR_MAX       4'hc
`define BWP_CONT_MAX  3'h2
`define FILL_HI_MSB   13
`define FILL_HI_LSB   8
`define FILL_LO_MSB   7
`define ST_FAULT_MSB  7
`define ST_FAULT_LSB  5
`define TRANS_BIT     1

// Interrupt status bits
`define IRQ_W         3
`define IRQ_OVF       0
`define IRQ_FAULT     1
`define IRQ_MOTION    2

`endif

//--- hw/accel_regs_pkg.sv
// Purpose: Types shared by the register slice and its users.
// Assumes: Constants come from accel_regs_consts.svh.
// Notes:   Struct layouts match the register bit layouts.
package accel_regs_pkg;

   typedef struct packed {
      logic       perf;
      logic [2:0] bwp;
      logic [3:0] odr;
   } accel_sampling_config_s;

   typedef enum logic [1:0] {
      MOTION_STILL   = 2'h0,
      MOTION_WALK    = 2'h1,
      MOTION_RUN     = 2'h2,
      MOTION_UNKNOWN = 2'h3
   } motion_e;

   typedef enum logic [4:0] {
      MSG_NOT_INIT = 5'h00,
      MSG_INIT_OK  = 5'h01,
      MSG_INIT_ERR = 5'h02,
      MSG_DRV_ERR  = 5'h03,
      MSG_STOPPED  = 5'h04
   } init_msg_e;

   typedef struct packed {
      logic      wake_rate_fault;
      logic      low_rate_feature_fault;
      logic      remap_fault;
      init_msg_e msg;
   } core_state_s;

   typedef enum logic [2:0] {
      PH_IDLE  = 3'b001,
      PH_READ  = 3'b010,
      PH_WRITE = 3'b100
   } phase_e;

endpackage

//--- hw/accel_status_config_regs.sv
// Purpose: AHB-Lite register slice: buffer fill count and read port,
//          motion class, internal state, sampling configuration.
// Assumes: Core inputs are on clk; DEPTH is a power of two.
// Notes:   Zero wait states; read data registered in address phase.
//
// How it works
// - Fill-count high register returns count bits 13..8 in 5..0.
// - Fill-count low register returns count bits 7..0.
// - The read port register returns buffered sensor bytes.
// - Motion register returns the 2-bit class still/walk/run/unknown.
// - State register low five bits give the initialisation message.
// - State bit 5 shows an invalid axis remapping.
// - State bit 6 shows a rate too low for 50 Hz based features.
// - State bit 7 shows a rate too low for wake-up detection.
// - Rate code 1..12 selects 25/32 Hz doubled per step, others reserved.
// - The selected rate does not depend on any power mode.
// - Config bit 7 picks averaging (0) or continuous filter (1).
// - In filter mode bandwidth codes 0..2 give OSR4, OSR2, normal.
// - In averaging mode bandwidth code n averages 2^n samples.
// - The configuration register resets to 0xa8.
`timescale 1ns/1ns
`include "accel_regs_consts.svh"

module accel_status_config_regs
   import accel_regs_pkg::*;
#(
   parameter int DEPTH = 1024,
   parameter int CNT_W = 14
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Sample bytes from the core
   input  wire logic        push_valid,
   input  wire logic [7:0]  push_data,
   output logic             push_ready,
   // Core state
   input  wire motion_e     motion_class,
   input  wire core_state_s core_state,
   // Sampling configuration
   output accel_sampling_config_s        accel_sampling_config,
   output logic             cont_filter,
   output logic [1:0]       osr_sel,
   output logic [7:0]       avg_count,
   output logic [11:0]      rate_mult,
   output logic             rate_valid,
   output logic             bw_valid,
   // Interrupt
   output logic             irq
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(DEPTH);

   ////////////////////////////////////////////////////////////////////
   // Bus decode

   logic [9:0]        idx;
   logic              addr_ok;
   logic              acc;
   logic              rd_acc;
   logic              wr_acc;
   logic              sel_fill_lo;
   logic              sel_fill_hi;
   logic              sel_rd_port;
   logic              sel_motion;
   logic              sel_state;
   logic              sel_irq_stat;
   logic              sel_irq_mask;
   logic              sel_conf;

   assign idx     = haddr[11:2];
   assign addr_ok = (haddr[31:12] == '0) && (haddr[1:0] == 2'h0);
   assign acc     = hsel && htrans[`TRANS_BIT] && hready;
   assign rd_acc  = acc && !hwrite;
   assign wr_acc  = acc && hwrite;

   assign sel_fill_lo  = addr_ok && (idx == `IDX_FILL_LO);
   assign sel_fill_hi  = addr_ok && (idx == `IDX_FILL_HI);
   assign sel_rd_port  = addr_ok && (idx == `IDX_RD_PORT);
   assign sel_motion   = addr_ok && (idx == `IDX_MOTION);
   assign sel_state    = addr_ok && (idx == `IDX_STATE);
   assign sel_irq_stat = addr_ok && (idx == `IDX_IRQ_STAT);
   assign sel_irq_mask = addr_ok && (idx == `IDX_IRQ_MASK);
   assign sel_conf     = addr_ok && (idx == `IDX_CONF);

   // Never stalls, never errors
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   ////////////////////////////////////////////////////////////////////
   // Data phase tracking

   phase_e            ph_reg;
   phase_e            ph_next;
   logic [9:0]        widx_reg;
   logic              wok_reg;

   always_comb begin
      case (1'b1)
         wr_acc:  ph_next = PH_WRITE;
         rd_acc:  ph_next = PH_READ;
         default: ph_next = PH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ph_reg   <= PH_IDLE;
         widx_reg <= 10'h000;
         wok_reg  <= 1'b0;
      end else begin
         ph_reg   <= ph_next;
         widx_reg <= idx;
         wok_reg  <= addr_ok;
      end
   end

   logic              wr_now;
   logic              wr_conf;
   logic              wr_mask;

   always_comb begin
      case (ph_reg)
         PH_WRITE: wr_now = wok_reg;
         PH_READ:  wr_now = 1'b0;
         PH_IDLE:  wr_now = 1'b0;
         default:  wr_now = 1'b0;
      endcase
   end

   assign wr_conf = wr_now && (widx_reg == `IDX_CONF);
   assign wr_mask = wr_now && (widx_reg == `IDX_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////
   // Sample byte buffer

   logic [7:0]        mem [DEPTH];
   logic [PTR_W-1:0]  wr_ptr_reg;
   logic [PTR_W-1:0]  rd_ptr_reg;
   logic [CNT_W-1:0]  count_reg;
   logic [CNT_W-1:0]  count_next;
   logic              push;
   logic              pop;
   logic              empty;

   assign empty      = (count_reg == '0);
   assign push_ready = (count_reg < DEPTH_CNT);
   assign push       = push_valid && push_ready;
   // Reading an empty port pops nothing
   assign pop        = rd_acc && sel_rd_port && !empty;
   assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);

   // Storage has no reset; pointers and count define its content
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= push_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + PTR_W'(push);
         rd_ptr_reg <= rd_ptr_reg + PTR_W'(pop);
         count_reg  <= count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration

   accel_sampling_config_s         conf_reg;
   accel_sampling_config_s         conf_next;
   logic [`IRQ_W-1:0] mask_reg;

   // Reset value feeds the decode too, so outputs agree at release
   assign conf_next = !rst_n  ? accel_sampling_config_s'(`CONF_RST) :
                      wr_conf ? accel_sampling_config_s'(hwdata[7:0]) : conf_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conf_reg <= accel_sampling_config_s'(`CONF_RST);
         mask_reg <= `IRQ_MASK_RST;
      end else begin
         conf_reg <= conf_next;
         if (wr_mask) begin
            mask_reg <= hwdata[`IRQ_W-1:0];
         end
      end
   end

   assign accel_sampling_config = conf_reg;

   // Decoded settings, registered in step with conf_reg
   logic              rate_ok_next;
   logic              bw_ok_next;
   logic [11:0]       rate_next;
   logic [1:0]        osr_next;
   logic [7:0]        avg_next;

   assign rate_ok_next = (conf_next.odr >= `ODR_MIN) &&
                         (conf_next.odr <= `ODR_MAX);
   // Units of 25/32 Hz; no power mode input narrows it
   assign rate_next = rate_ok_next ?
          (12'h001 << (conf_next.odr - `ODR_MIN)) : 12'h000;
   assign bw_ok_next = !conf_next.perf ||
                       (conf_next.bwp <= `BWP_CONT_MAX);
   assign osr_next = (conf_next.perf && bw_ok_next) ?
                     conf_next.bwp[1:0] : 2'h0;
   assign avg_next = conf_next.perf ?
                     8'h01 : (8'h01 << conf_next.bwp);

   always_ff @(posedge clk) begin
      rate_valid  <= rate_ok_next;
      bw_valid    <= bw_ok_next;
      rate_mult   <= rate_next;
      osr_sel     <= osr_next;
      avg_count   <= avg_next;
      cont_filter <= conf_next.perf;
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt status, cleared by read

   logic [`IRQ_W-1:0] irq_reg;
   logic [`IRQ_W-1:0] irq_next;
   logic [`IRQ_W-1:0] ev;
   logic [2:0]        fault_prev_reg;
   logic [2:0]        fault_now;
   motion_e           motion_prev_reg;
   logic              rd_irq;

   assign fault_now = core_state[`ST_FAULT_MSB:`ST_FAULT_LSB];
   assign rd_irq    = rd_acc && sel_irq_stat;

   assign ev[`IRQ_OVF]    = push_valid && !push_ready;
   assign ev[`IRQ_FAULT]  = |(fault_now & ~fault_prev_reg);
   assign ev[`IRQ_MOTION] = (motion_class != motion_prev_reg);

   // A new event beats a clearing read in the same cycle
   assign irq_next = (irq_reg & ~{`IRQ_W{rd_irq}}) | ev;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_reg         <= '0;
         fault_prev_reg  <= 3'h0;
         motion_prev_reg <= MOTION_STILL;
      end else begin
         irq_reg         <= irq_next;
         fault_prev_reg  <= fault_now;
         motion_prev_reg <= motion_class;
      end
   end

   assign irq = |(irq_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////
   // Read data

   logic [7:0]        rd_byte;
   logic [7:0]        fill_lo_byte;
   logic [7:0]        fill_hi_byte;
   logic [7:0]        port_byte;
   logic [7:0]        hrdata_reg;

   assign fill_lo_byte = count_reg[`FILL_LO_MSB:0];
   assign fill_hi_byte =
          {2'b00, count_reg[`FILL_HI_MSB:`FILL_HI_LSB]};
   assign port_byte = empty ? `EMPTY_BYTE : mem[rd_ptr_reg];

   assign rd_byte =
      sel_fill_lo  ? fill_lo_byte :
      sel_fill_hi  ? fill_hi_byte :
      sel_rd_port  ? port_byte :
      sel_motion   ? {6'h00, motion_class} :
      sel_state    ? core_state :
      sel_irq_stat ? {5'h00, irq_reg} :
      sel_irq_mask ? {5'h00, mask_reg} :
      sel_conf     ? conf_reg : 8'h00;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hrdata_reg <= 8'h00;
      end else if (rd_acc) begin
         hrdata_reg <= rd_byte;
      end
   end

   assign hrdata = {24'h000000, hrdata_reg};

   ////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_fill_hi;
      rd_acc && sel_fill_hi |=> hrdata ==
         {26'h0, $past(count_reg[`FILL_HI_MSB:`FILL_HI_LSB])};
   endproperty
   a_fill_hi: assert property (p_fill_hi)
      else $error("fill high read wrong");

   property p_fill_lo;
      rd_acc && sel_fill_lo |=>
         hrdata == {24'h0, $past(count_reg[`FILL_LO_MSB:0])};
   endproperty
   a_fill_lo: assert property (p_fill_lo)
      else $error("fill low read wrong");

   property p_empty_port;
      rd_acc && sel_rd_port && empty |=> hrdata == 32'h0;
   endproperty
   a_empty_port: assert property (p_empty_port)
      else $error("empty port read not zero");

   property p_pop_count;
      pop && !push |=> count_reg == $past(count_reg) - CNT_W'(1);
   endproperty
   a_pop_count: assert property (p_pop_count)
      else $error("pop did not lower count");

   property p_motion;
      rd_acc && sel_motion |=>
         hrdata == {30'h0, $past(motion_class)};
   endproperty
   a_motion: assert property (p_motion)
      else $error("motion read wrong");

   property p_state;
      rd_acc && sel_state |=>
         hrdata == {24'h0, $past(core_state)};
   endproperty
   a_state: assert property (p_state)
      else $error("state read wrong");

   property p_conf_wr;
      wr_conf |=> accel_sampling_config == $past(hwdata[7:0]) &&
                  cont_filter == $past(hwdata[7]);
   endproperty
   a_conf_wr: assert property (p_conf_wr)
      else $error("config write lost");

   property p_avg;
      !accel_sampling_config.perf |-> avg_count == (8'h01 << accel_sampling_config.bwp);
   endproperty
   a_avg: assert property (p_avg)
      else $error("averaging count wrong");

   property p_osr;
      accel_sampling_config.perf && accel_sampling_config.bwp <= `BWP_CONT_MAX |->
         bw_valid && osr_sel == accel_sampling_config.bwp[1:0];
   endproperty
   a_osr: assert property (p_osr)
      else $error("filter select wrong");

   property p_conf_reset;
      $rose(rst_n) |-> accel_sampling_config == `CONF_RST;
   endproperty
   a_conf_reset: assert property (p_conf_reset)
      else $error("config reset value wrong");

   property p_ovf_irq;
      push_valid && !push_ready && mask_reg[`IRQ_OVF] |=> irq;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq)
      else $error("overflow interrupt missing");

   c_pop:       cover property (pop ##1 pop);
   c_full:      cover property (push_valid && !push_ready);
   c_conf_wr:   cover property (wr_conf);
   c_irq_clear: cover property (irq ##1 rd_irq ##1 !irq);

endmodule

//--- tb/accel_status_config_regs_test.sv
// Purpose: Self-checking bench for the sensor register slice.
// Assumes: Zero-wait slave; host model issues the bus cycles.
// Notes:   Buffer is filled once to DEPTH to raise the overflow event.
`timescale 1ns/1ns
`include "accel_regs_consts.svh"

module accel_status_config_regs_test;
   import accel_regs_pkg::*;

   logic        clk, rst_n, hsel, hwrite, hresp, irq, hready, stuck;
   logic        push_valid, push_ready, cont_filter, rate_valid, bw_valid;
   logic        p;
   logic [31:0] haddr, hwdata, hrdata, rv, v;
   logic [1:0]  htrans, osr_sel;
   logic [2:0]  hsize, b;
   logic [7:0]  push_data, avg_count;
   logic [11:0] rate_mult;
   accel_sampling_config_s   accel_sampling_config;
   motion_e     motion_class;
   core_state_s core_state;
   int          failures, compares, i;

   ahb_host u_host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .stuck(stuck));

   accel_status_config_regs u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .push_valid(push_valid), .push_data(push_data),
      .push_ready(push_ready), .motion_class(motion_class),
      .core_state(core_state), .accel_sampling_config(accel_sampling_config),
      .cont_filter(cont_filter), .osr_sel(osr_sel), .avg_count(avg_count),
      .rate_mult(rate_mult), .rate_valid(rate_valid), .bw_valid(bw_valid),
      .irq(irq));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic xfer(input logic w, input logic [9:0] idx,
                       input logic [31:0] d);
      u_host.xfer(w, {20'h0, idx, 2'h0}, d, rv);
      if (stuck) begin
         failures++;
         end_of_test();
      end
   endtask

   task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0);
      chk(rv, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_of_test();
   end

   initial begin
      rst_n = 1'b0;
      push_valid = 1'b0;
      push_data = 8'h00;
      motion_class = MOTION_STILL;
      core_state = '0;
      failures = 0;
      compares = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk({24'h0, accel_sampling_config}, 32'ha8);
      chk({cont_filter, osr_sel, avg_count, rate_mult, rate_valid, bw_valid},
          {1'b1, 2'h2, 8'h01, 12'h080, 1'b1, 1'b1});
      rchk(`IDX_CONF, 32'ha8);
      rchk(`IDX_RD_PORT, 32'h0);
      // Over 256 bytes so the high count byte moves
      for (i = 0; i < 260; i++) begin
         push_data <= i[7:0];
         push_valid <= 1'b1;
         @(posedge clk);
      end
      push_valid <= 1'b0;
      rchk(`IDX_FILL_HI, 32'h1);
      rchk(`IDX_FILL_LO, 32'h4);
      rchk(`IDX_RD_PORT, 32'h0);
      rchk(`IDX_RD_PORT, 32'h1);
      rchk(`IDX_FILL_LO, 32'h2);
      xfer(1'b1, `IDX_FILL_HI, 32'hff);
      rchk(`IDX_FILL_HI, 32'h1);
      rchk(10'h3ff, 32'h0);
      for (i = 3; i >= 0; i--) begin
         @(posedge clk);
         motion_class <= motion_e'(i[1:0]);
         rchk(`IDX_MOTION, 32'(i));
      end
      chk({31'h0, irq}, 32'h0);
      // Messages 0..4, then each fault bit alone
      for (i = 0; i < 8; i++) begin
         v = (i < 5) ? 32'(i) : 32'(1 << i);
         @(posedge clk);
         core_state <= core_state_s'(v[7:0]);
         rchk(`IDX_STATE, v);
      end
      for (i = 0; i < 16; i++) begin
         xfer(1'b1, `IDX_CONF, 32'ha0 | 32'(i));
         @(posedge clk);
         #1;
         p = (i >= 1 && i <= 12);
         chk({rate_valid, rate_mult}, {p, p ? 12'(1 << (i - 1)) : 12'h0});
      end
      for (i = 0; i < 16; i++) begin
         p = i[3];
         b = i[2:0];
         xfer(1'b1, `IDX_CONF, {24'h0, p, b, 4'h8});
         @(posedge clk);
         #1;
         chk({cont_filter, avg_count, osr_sel, bw_valid},
             {p, p ? 8'h1 : 8'(1 << b), (p && b <= 2) ? b[1:0] : 2'h0,
              !p || b <= 2});
         rchk(`IDX_CONF, {24'h0, p, b, 4'h8});
      end
      // Motion and fault events wait behind the mask
      xfer(1'b1, `IDX_IRQ_MASK, 32'h4);
      @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h1);
      rchk(`IDX_IRQ_MASK, 32'h4);
      rchk(`IDX_IRQ_STAT, 32'h6);
      #1;
      chk({31'h0, irq}, 32'h0);
      rchk(`IDX_IRQ_STAT, 32'h0);
      // 258 stored; 766 more reach the depth of 1024, one more overflows
      xfer(1'b1, `IDX_IRQ_MASK, 32'h1);
      push_valid <= 1'b1;
      for (i = 0; i < 767; i++) begin
         @(posedge clk);
      end
      push_valid <= 1'b0;
      #1;
      chk({30'h0, push_ready, irq}, 32'h1);
      rchk(`IDX_FILL_HI, 32'h4);
      rchk(`IDX_FILL_LO, 32'h0);
      rchk(`IDX_IRQ_STAT, 32'h1);
      rchk(`IDX_RD_PORT, 32'h2);
      #1;
      chk({29'h0, hresp, push_ready, irq}, 32'h2);
      end_of_test();
   end

endmodule

//--- tb/ahb_host.sv
// Purpose: Host model: single-word AHB-Lite master for the register slice.
// Assumes: One slave; its hreadyout is the bus hready.
// Notes:   Sets stuck when a bounded wait for hready runs out.
`timescale 1ns/1ns

module ahb_host (
   // Bus clock
   input  wire logic        clk,
   // Master request
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   // Slave answer
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // Wait limit reached
   output logic             stuck
);

   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      stuck = 1'b0;
   end

   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) stuck = 1'b1;
   endtask

   task automatic xfer(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      // Idle address shows junk so a stale address is never trusted
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~a;
      hwdata <= d;
      wait_ready();
      r = hrdata;
      hwdata <= ~d;
   endtask

endmodule
